// >>> ead_pkg.sv
package ead_pkg;

   // addressing-mode byte field positions
   localparam int MOD_HI = 7;
   localparam int MOD_LO = 6;
   localparam int REG_HI = 5;
   localparam int REG_LO = 3;
   localparam int RM_HI  = 2;
   localparam int RM_LO  = 0;

   // displacement selector codes
   localparam logic [1:0] MOD_NODISP = 2'h0;
   localparam logic [1:0] MOD_DISP8  = 2'h1;
   localparam logic [1:0] MOD_DISP16 = 2'h2;
   localparam logic [1:0] MOD_REG    = 2'h3;

   // operand locator codes with special meaning
   localparam logic [2:0] RM_BP_SI = 3'h2;
   localparam logic [2:0] RM_BP_DI = 3'h3;
   localparam logic [2:0] RM_DIRECT = 3'h6;

   // segment override prefix: 001xx110
   localparam logic [7:0] PFX_MASK  = 8'hE7;
   localparam logic [7:0] PFX_MATCH = 8'h26;
   localparam int PFX_SEG_HI = 4;
   localparam int PFX_SEG_LO = 3;

   // address computation length and segment shift
   localparam logic [2:0] EA_CYCLES = 3'h4;
   localparam int         SEG_SHIFT = 4;

   // reset values
   localparam logic [15:0] EA_RESET   = 16'h0000;
   localparam logic [19:0] PHYS_RESET = 20'h00000;

   typedef enum logic [1:0] {
      SEG_EXTRA = 2'b00,
      SEG_CODE  = 2'b01,
      SEG_STACK = 2'b10,
      SEG_DATA  = 2'b11
   } ead_seg_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_FETCH = 3'b001,
      ST_CALC  = 3'b010,
      ST_PHYS  = 3'b011,
      ST_DONE  = 3'b100
   } ead_state_t;

endpackage

// >>> ead_disp_collect.sv
`timescale 1ns/100ps
`default_nettype none
module ead_disp_collect (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        clear,
   input  wire logic        take,
   input  wire logic [7:0]  byteIn,
   input  wire logic        signExt,
   output logic      [15:0] disp,
   output logic      [1:0]  count
);
   logic [7:0] lowQ, lowD, highQ, highD;
   logic [1:0] countQ, countD;

   always_comb begin
      lowD   = lowQ;
      highD  = highQ;
      countD = countQ;
      if (clear) begin
         lowD   = 8'h00;
         highD  = 8'h00;
         countD = 2'h0;
      end else if (take) begin
         // low byte arrives first, high byte second
         if (countQ == 2'h0) begin
            lowD = byteIn;
         end else begin
            highD = byteIn;
         end
         countD = countQ + 2'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         lowQ   <= 8'h00;
         highQ  <= 8'h00;
         countQ <= 2'h0;
      end else begin
         lowQ   <= lowD;
         highQ  <= highD;
         countQ <= countD;
      end
   end

   // one byte is sign-extended, two bytes are joined high over low
   assign disp  = signExt ? {{8{lowQ[7]}}, lowQ} : {highQ, lowQ};
   assign count = countQ;

   a_sign_extend: assert property (
      @(posedge clock) disable iff (!resetn)
      (signExt && countQ == 2'h1) |-> (disp[15:8] == {8{disp[7]}}))
      else $error("short displacement not sign-extended");

   a_byte_order: assert property (
      @(posedge clock) disable iff (!resetn)
      (take && !clear && countQ == 2'h1) |=> (highQ == $past(byteIn)))
      else $error("second displacement byte not placed high");
endmodule
`default_nettype wire

// >>> ead_phys_form.sv
`timescale 1ns/100ps
`default_nettype none
module ead_phys_form (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        load,
   input  wire logic [15:0] segBase,
   input  wire logic [15:0] offset,
   output logic      [19:0] phys
);
   logic [19:0] physQ, physD;

   always_comb begin
      physD = physQ;
      if (load) begin
         physD = {segBase, {ead_pkg::SEG_SHIFT{1'b0}}}
               + {4'h0, offset};
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         physQ <= ead_pkg::PHYS_RESET;
      end else begin
         physQ <= physD;
      end
   end

   assign phys = physQ;

   a_phys_sum: assert property (
      @(posedge clock) disable iff (!resetn)
      load |=> (phys == ({$past(segBase), 4'h0} + {4'h0, $past(offset)})))
      else $error("physical address is not segment times 16 plus offset");
endmodule
`default_nettype wire

// >>> ead_effective_address_decode.sv
`timescale 1ns/100ps
`default_nettype none
module ead_effective_address_decode (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        start,
   input  wire logic [7:0]  modRm,
   input  wire logic        wordOp,
   input  wire logic        stringDest,
   input  wire logic        prefixValid,
   input  wire logic [7:0]  prefixByte,
   input  wire logic        streamValid,
   input  wire logic [7:0]  streamByte,
   input  wire logic [15:0] generalBasePtr,
   input  wire logic [15:0] frameBasePtr,
   input  wire logic [15:0] srcIndexPtr,
   input  wire logic [15:0] destIndexPtr,
   input  wire logic [15:0] extraSegBase,
   input  wire logic [15:0] codeSegBase,
   input  wire logic [15:0] stackSegBase,
   input  wire logic [15:0] dataSegBase,
   output logic             busy,
   output logic             wantByte,
   output logic             done,
   output logic             isRegOperand,
   output logic      [2:0]  regSelIdx,
   output logic             regSelHigh,
   output logic      [2:0]  rmSelIdx,
   output logic             rmSelHigh,
   output logic      [15:0] effectiveAddress,
   output logic      [1:0]  segSel,
   output logic             overrideSeen,
   output logic      [19:0] physAddr
);
   ead_pkg::ead_state_t stateQ, stateD;
   logic [1:0]  modQ, modD;
   logic [2:0]  rmQ, rmD;
   logic        strQ, strD;
   logic        ovrQ, ovrD;
   logic [1:0]  ovrSegQ, ovrSegD;
   logic [2:0]  cntQ, cntD;
   logic [15:0] eaQ, eaD;
   logic [1:0]  segQ, segD;
   logic        isRegQ, isRegD;
   logic [3:0]  regDecQ, regDecD, rmDecQ, rmDecD;
   logic        wantQ, wantD, doneQ, doneD, busyQ, busyD;
   logic [1:0]  needBytes;
   logic        take, clearDisp, physLoad;
   logic [15:0] disp, segBase;
   logic [1:0]  dispCount;

   // register code to {word index, high-byte flag}
   function automatic logic [3:0] regDecode(input logic [2:0] code,
                                            input logic       isWord);
      if (isWord) begin
         regDecode = {code, 1'b0};
      end else begin
         regDecode = {1'b0, code[1:0], code[2]};
      end
   endfunction

   // displacement bytes expected for a selector/locator pair
   function automatic logic [1:0] dispBytes(input logic [1:0] md,
                                            input logic [2:0] rm);
      unique case (md)
         ead_pkg::MOD_DISP8:  dispBytes = 2'h1;
         ead_pkg::MOD_DISP16: dispBytes = 2'h2;
         ead_pkg::MOD_NODISP: dispBytes = (rm == ead_pkg::RM_DIRECT)
                                          ? 2'h2 : 2'h0;
         ead_pkg::MOD_REG:    dispBytes = 2'h0;
      endcase
   endfunction

   // true when the operand is addressed through the frame base
   function automatic logic usesFrame(input logic [1:0] md,
                                      input logic [2:0] rm);
      usesFrame = (rm == ead_pkg::RM_BP_SI) || (rm == ead_pkg::RM_BP_DI)
                || (rm == ead_pkg::RM_DIRECT && md != ead_pkg::MOD_NODISP);
   endfunction

   assign needBytes = dispBytes(modQ, rmQ);
   assign take      = wantQ && streamValid;
   assign clearDisp = (stateQ == ead_pkg::ST_IDLE);
   assign physLoad  = (stateQ == ead_pkg::ST_PHYS);

   ead_disp_collect u_disp (
      .clock   (clock),
      .resetn  (resetn),
      .clear   (clearDisp),
      .take    (take),
      .byteIn  (streamByte),
      .signExt (modQ == ead_pkg::MOD_DISP8),
      .disp    (disp),
      .count   (dispCount)
   );

   always_comb begin
      unique case (segQ)
         ead_pkg::SEG_EXTRA: segBase = extraSegBase;
         ead_pkg::SEG_CODE:  segBase = codeSegBase;
         ead_pkg::SEG_STACK: segBase = stackSegBase;
         ead_pkg::SEG_DATA:  segBase = dataSegBase;
      endcase
   end

   ead_phys_form u_phys (
      .clock   (clock),
      .resetn  (resetn),
      .load    (physLoad),
      .segBase (segBase),
      .offset  (eaQ),
      .phys    (physAddr)
   );

   always_comb begin
      stateD  = stateQ;
      modD    = modQ;
      rmD     = rmQ;
      strD    = strQ;
      ovrD    = ovrQ;
      ovrSegD = ovrSegQ;
      cntD    = cntQ;
      eaD     = eaQ;
      segD    = segQ;
      isRegD  = isRegQ;
      regDecD = regDecQ;
      rmDecD  = rmDecQ;
      unique case (stateQ)
         ead_pkg::ST_IDLE: begin
            if (prefixValid
                && (prefixByte & ead_pkg::PFX_MASK) == ead_pkg::PFX_MATCH)
            begin
               ovrD    = 1'b1;
               ovrSegD = prefixByte[ead_pkg::PFX_SEG_HI:ead_pkg::PFX_SEG_LO];
            end
            if (start) begin
               modD    = modRm[ead_pkg::MOD_HI:ead_pkg::MOD_LO];
               rmD     = modRm[ead_pkg::RM_HI:ead_pkg::RM_LO];
               strD    = stringDest;
               regDecD = regDecode(modRm[ead_pkg::REG_HI:ead_pkg::REG_LO],
                                   wordOp);
               rmDecD  = regDecode(modRm[ead_pkg::RM_HI:ead_pkg::RM_LO],
                                   wordOp);
               cntD    = 3'h1;
               if (modD == ead_pkg::MOD_REG) begin
                  isRegD = 1'b1;
                  stateD = ead_pkg::ST_DONE;
               end else begin
                  isRegD = 1'b0;
                  stateD = (dispBytes(modD, rmD) == 2'h0)
                           ? ead_pkg::ST_CALC : ead_pkg::ST_FETCH;
               end
            end
         end
         ead_pkg::ST_FETCH: begin
            if (take && (dispCount + 2'h1) == needBytes) begin
               stateD = ead_pkg::ST_CALC;
            end
         end
         ead_pkg::ST_CALC: begin
            cntD = cntQ + 3'h1;
            if (cntQ == ead_pkg::EA_CYCLES) begin
               stateD = ead_pkg::ST_PHYS;
               if (modQ == ead_pkg::MOD_NODISP
                   && rmQ == ead_pkg::RM_DIRECT) begin
                  eaD = disp;
               end else begin
                  unique case (rmQ)
                     3'h0: eaD = generalBasePtr + srcIndexPtr + disp;
                     3'h1: eaD = generalBasePtr + destIndexPtr + disp;
                     3'h2: eaD = frameBasePtr + srcIndexPtr + disp;
                     3'h3: eaD = frameBasePtr + destIndexPtr + disp;
                     3'h4: eaD = srcIndexPtr + disp;
                     3'h5: eaD = destIndexPtr + disp;
                     3'h6: eaD = frameBasePtr + disp;
                     3'h7: eaD = generalBasePtr + disp;
                  endcase
               end
               if (strQ) begin
                  segD = ead_pkg::SEG_EXTRA;
               end else if (ovrQ) begin
                  segD = ovrSegQ;
               end else if (usesFrame(modQ, rmQ)) begin
                  segD = ead_pkg::SEG_STACK;
               end else begin
                  segD = ead_pkg::SEG_DATA;
               end
            end
         end
         ead_pkg::ST_PHYS: begin
            stateD = ead_pkg::ST_DONE;
         end
         ead_pkg::ST_DONE: begin
            ovrD   = 1'b0;
            stateD = ead_pkg::ST_IDLE;
         end
         default: begin
            stateD = ead_pkg::ST_IDLE;
         end
      endcase
      wantD = (stateD == ead_pkg::ST_FETCH);
      doneD = (stateD == ead_pkg::ST_DONE);
      busyD = (stateD != ead_pkg::ST_IDLE);
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         stateQ  <= ead_pkg::ST_IDLE;
         modQ    <= 2'h0;
         rmQ     <= 3'h0;
         strQ    <= 1'b0;
         ovrQ    <= 1'b0;
         ovrSegQ <= 2'h0;
         cntQ    <= 3'h0;
         eaQ     <= ead_pkg::EA_RESET;
         segQ    <= ead_pkg::SEG_DATA;
         isRegQ  <= 1'b0;
         regDecQ <= 4'h0;
         rmDecQ  <= 4'h0;
         wantQ   <= 1'b0;
         doneQ   <= 1'b0;
         busyQ   <= 1'b0;
      end else begin
         stateQ  <= stateD;
         modQ    <= modD;
         rmQ     <= rmD;
         strQ    <= strD;
         ovrQ    <= ovrD;
         ovrSegQ <= ovrSegD;
         cntQ    <= cntD;
         eaQ     <= eaD;
         segQ    <= segD;
         isRegQ  <= isRegD;
         regDecQ <= regDecD;
         rmDecQ  <= rmDecD;
         wantQ   <= wantD;
         doneQ   <= doneD;
         busyQ   <= busyD;
      end
   end

   assign busy             = busyQ;
   assign wantByte         = wantQ;
   assign done             = doneQ;
   assign isRegOperand     = isRegQ;
   assign regSelIdx        = regDecQ[3:1];
   assign regSelHigh       = regDecQ[0];
   assign rmSelIdx         = rmDecQ[3:1];
   assign rmSelHigh        = rmDecQ[0];
   assign effectiveAddress = eaQ;
   assign segSel           = segQ;
   assign overrideSeen     = ovrQ;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence calcRun;
      (stateQ == ead_pkg::ST_CALC) [*4] ##1 (stateQ == ead_pkg::ST_PHYS);
   endsequence

   a_reg_form: assert property (
      (stateQ == ead_pkg::ST_IDLE && start
       && modRm[ead_pkg::MOD_HI:ead_pkg::MOD_LO] == ead_pkg::MOD_REG)
      |=> isRegOperand && busy ##0 done && !wantByte)
      else $error("register form did not finish as register operand");
   a_zero_disp: assert property (
      (stateQ == ead_pkg::ST_CALC && modQ == 2'b00 && rmQ != 3'b110)
      |-> disp == 16'h0000 && dispCount == 2'h0)
      else $error("selector 00 displacement not zero");
   a_pair_ea: assert property (
      (stateQ == ead_pkg::ST_CALC && cntQ == 3'h4 && modQ != 2'b00
       && rmQ == 3'h0)
      |=> effectiveAddress == $past(16'(generalBasePtr + srcIndexPtr + disp)))
      else $error("base plus source index form wrong");
   a_frame_dest: assert property (
      (stateQ == ead_pkg::ST_CALC && cntQ == 3'h4 && rmQ == 3'h3)
      |=> effectiveAddress == $past(16'(frameBasePtr + destIndexPtr + disp)))
      else $error("frame base plus dest index form wrong");
   a_single_reg: assert property (
      (stateQ == ead_pkg::ST_CALC && cntQ == 3'h4 && rmQ == 3'h7)
      |=> effectiveAddress == $past(16'(generalBasePtr + disp)))
      else $error("general base single register form wrong");
   a_direct_addr: assert property (
      (stateQ == ead_pkg::ST_CALC && cntQ == 3'h4 && modQ == 2'b00
       && rmQ == 3'h6) |=> effectiveAddress == $past(disp)
      ##0 segSel == (strQ ? 2'b00 : ovrQ ? ovrSegQ : 2'b11))
      else $error("direct address form wrong");
   a_fetch_bytes: assert property (
      $rose(stateQ == ead_pkg::ST_CALC) && $past(wantByte)
      |-> dispCount == needBytes && !wantByte)
      else $error("displacement byte count wrong");
   a_calc_four: assert property (
      $rose(stateQ == ead_pkg::ST_CALC) |-> calcRun ##1 done)
      else $error("address computation not four cycles");
   a_override_seg: assert property (
      (stateQ == ead_pkg::ST_IDLE && prefixValid
       && prefixByte[7:5] == 3'b001 && prefixByte[2:0] == 3'b110)
      |=> overrideSeen && ovrSegQ == $past(prefixByte[4:3]))
      else $error("segment override prefix not caught");
   a_byte_regs: assert property (
      (stateQ == ead_pkg::ST_IDLE && start && !wordOp)
      |=> regSelIdx[2] == 1'b0 && regSelHigh == $past(modRm[5]))
      else $error("byte register decode wrong");
   a_frame_stack: assert property (
      (stateQ == ead_pkg::ST_PHYS && !strQ && !ovrQ
       && (rmQ == 3'h2 || rmQ == 3'h3)) |-> segSel == 2'b10)
      else $error("frame base operand not on stack segment");
   a_string_extra: assert property (
      (stateQ == ead_pkg::ST_PHYS && strQ) |-> segSel == 2'b00)
      else $error("string destination not on extra segment");
endmodule
`default_nettype wire

// >>> ead_effective_address_decode_test.sv
`timescale 1ns/100ps
`default_nettype none
module ead_effective_address_decode_test;
   logic        clock, resetn, start, wordOp, stringDest;
   logic        prefixValid, streamValid;
   logic [7:0]  modRm, prefixByte, streamByte;
   logic [15:0] generalBasePtr, frameBasePtr, srcIndexPtr, destIndexPtr;
   logic [15:0] extraSegBase, codeSegBase, stackSegBase, dataSegBase;
   logic        busy, wantByte, done, isRegOperand, regSelHigh, rmSelHigh;
   logic        overrideSeen;
   logic [2:0]  regSelIdx, rmSelIdx;
   logic [15:0] effectiveAddress;
   logic [1:0]  segSel;
   logic [19:0] physAddr;
   logic [7:0]  dispBytes [0:2];
   int          errCount;
   int          numChecks;

   ead_effective_address_decode dut (
      .clock, .resetn, .start, .modRm, .wordOp, .stringDest,
      .prefixValid, .prefixByte, .streamValid, .streamByte,
      .generalBasePtr, .frameBasePtr, .srcIndexPtr, .destIndexPtr,
      .extraSegBase, .codeSegBase, .stackSegBase, .dataSegBase,
      .busy, .wantByte, .done, .isRegOperand, .regSelIdx, .regSelHigh,
      .rmSelIdx, .rmSelHigh, .effectiveAddress, .segSel, .overrideSeen,
      .physAddr
   );

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic results;
      $display("checks %0d mismatches %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      numChecks++;
      if (got !== exp) begin
         errCount++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [15:0] seg_val(input logic [1:0] s);
      case (s)
         2'h0: seg_val = extraSegBase;
         2'h1: seg_val = codeSegBase;
         2'h2: seg_val = stackSegBase;
         default: seg_val = dataSegBase;
      endcase
   endfunction

   function automatic logic [15:0] exp_ea(input logic [7:0] mr,
                                          input logic [15:0] disp);
      case (mr[2:0])
         3'h0: exp_ea = generalBasePtr + srcIndexPtr + disp;
         3'h1: exp_ea = generalBasePtr + destIndexPtr + disp;
         3'h2: exp_ea = frameBasePtr + srcIndexPtr + disp;
         3'h3: exp_ea = frameBasePtr + destIndexPtr + disp;
         3'h4: exp_ea = srcIndexPtr + disp;
         3'h5: exp_ea = destIndexPtr + disp;
         3'h6: exp_ea = (mr[7:6] == 2'h0) ? disp : frameBasePtr + disp;
         default: exp_ea = generalBasePtr + disp;
      endcase
   endfunction

   // compare address, segment choice and physical address
   task automatic judge(input logic [15:0] ea, input logic [1:0] sg);
      chk(20'(effectiveAddress), 20'(ea));
      chk(20'(segSel), 20'(sg));
      chk(physAddr, {seg_val(sg), 4'h0} + {4'h0, ea});
   endtask

   // one operation: start, feed bytes while asked, wait for done
   task automatic run_op(input logic [7:0] mr, input logic wo,
                         input logic sd, input logic pv,
                         input logic [7:0] pb, output int cyc,
                         output int taken);
      logic tk;
      @(negedge clock);
      modRm = mr;
      wordOp = wo;
      stringDest = sd;
      prefixValid = pv;
      prefixByte = pb;
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      prefixValid = 1'b0;
      cyc = 1;
      taken = 0;
      while (done !== 1'b1 && cyc < 40) begin
         tk = (wantByte === 1'b1);
         streamValid = tk;
         streamByte = dispBytes[taken];
         @(negedge clock);
         taken += int'(tk);
         cyc++;
      end
      streamValid = 1'b0;
   endtask

   task automatic t_register;
      logic [7:0] mr;
      int cyc, taken;
      for (int w = 0; w < 2; w++) begin
         for (int c = 0; c < 8; c++) begin
            mr = {2'h3, c[2:0], 3'(7 - c)};
            run_op(mr, w[0], 1'b0, 1'b0, 8'h00, cyc, taken);
            chk(20'(cyc), 20'h1);
            chk(20'(isRegOperand), 20'h1);
            chk(20'({regSelHigh, regSelIdx}), 20'(w[0] ? {1'b0, mr[5:3]}
                : {mr[5], 1'b0, mr[4:3]}));
            chk(20'({rmSelHigh, rmSelIdx}), 20'(w[0] ? {1'b0, mr[2:0]}
                : {mr[2], 1'b0, mr[1:0]}));
         end
      end
   endtask

   task automatic t_memory;
      logic [7:0]  mr;
      logic [15:0] disp;
      logic        bp;
      int cyc, taken, nb;
      for (int p = 0; p < 2; p++) begin
         dispBytes[0] = p[0] ? 8'h3C : 8'h85;
         dispBytes[1] = p[0] ? 8'h7E : 8'hC3;
         dispBytes[2] = 8'h5A;
         for (int m = 0; m < 3; m++) begin
            for (int r = 0; r < 8; r++) begin
               mr = {m[1:0], 3'h2, r[2:0]};
               nb = (m == 0 && r == 6) ? 2 : m;
               if (nb == 0)
                  disp = 16'h0000;
               else if (nb == 1)
                  disp = {{8{dispBytes[0][7]}}, dispBytes[0]};
               else
                  disp = {dispBytes[1], dispBytes[0]};
               bp = (r == 2 || r == 3 || (r == 6 && m != 0));
               run_op(mr, 1'b1, 1'b0, 1'b0, 8'h00, cyc, taken);
               chk(20'(cyc), 20'(6 + nb));
               chk(20'(taken), 20'(nb));
               chk(20'(isRegOperand), 20'h0);
               judge(exp_ea(mr, disp), bp ? 2'h2 : 2'h3);
            end
         end
      end
   endtask

   task automatic t_override;
      logic [15:0] disp;
      int cyc, taken;
      dispBytes[0] = 8'h85;
      disp = 16'hFF85;
      for (int s = 0; s < 4; s++) begin
         run_op(8'h42, 1'b1, 1'b0, 1'b1, {3'b001, s[1:0], 3'b110},
                cyc, taken);
         judge(exp_ea(8'h42, disp), s[1:0]);
         chk(20'(overrideSeen), 20'h1);
      end
      // a prefix alone while idle stays pending for the next operation
      @(negedge clock);
      prefixValid = 1'b1;
      prefixByte = 8'h2E;
      @(negedge clock);
      prefixValid = 1'b0;
      chk(20'(overrideSeen), 20'h1);
      run_op(8'h42, 1'b1, 1'b0, 1'b0, 8'h00, cyc, taken);
      judge(exp_ea(8'h42, disp), 2'h1);
      // byte outside the prefix pattern leaves the default
      run_op(8'h00, 1'b1, 1'b0, 1'b1, 8'h27, cyc, taken);
      judge(exp_ea(8'h00, 16'h0000), 2'h3);
      chk(20'(overrideSeen), 20'h0);
      run_op(8'h05, 1'b1, 1'b1, 1'b1, 8'h3E, cyc, taken);
      judge(exp_ea(8'h05, 16'h0000), 2'h0);
      run_op(8'h43, 1'b1, 1'b1, 1'b0, 8'h00, cyc, taken);
      judge(exp_ea(8'h43, disp), 2'h0);
   endtask

   initial begin
      repeat (5000) @(posedge clock);
      errCount++;
      results();
   end

   initial begin
      errCount = 0;
      numChecks = 0;
      resetn = 1'b0;
      start = 1'b0;
      modRm = 8'h00;
      wordOp = 1'b0;
      stringDest = 1'b0;
      prefixValid = 1'b0;
      prefixByte = 8'h00;
      streamValid = 1'b0;
      streamByte = 8'h00;
      generalBasePtr = 16'h1234;
      frameBasePtr = 16'hFF00;
      srcIndexPtr = 16'h0456;
      destIndexPtr = 16'h2001;
      extraSegBase = 16'h1000;
      codeSegBase = 16'h2100;
      stackSegBase = 16'h3200;
      dataSegBase = 16'hF430;
      repeat (6) @(negedge clock);
      chk(20'({busy, done, wantByte}), 20'h0);
      chk(20'(segSel), 20'h3);
      chk(physAddr, 20'h00000);
      resetn = 1'b1;
      t_register();
      t_memory();
      t_override();
      results();
   end
endmodule
`default_nettype wire
